// file: rtl/alarm_handler_defines.svh
// constants for the motor driver alarm handler
`ifndef ALARM_HANDLER_DEFINES_SVH
`define ALARM_HANDLER_DEFINES_SVH
`define CODE_NONE 8'h00
`define CODE_SUPPLY_OFF 8'h23
`define CODE_UNDERVOLT 8'h25
`define CODE_MOTOR_HOT 8'h26
`define CODE_SENSOR_RUN 8'h28
`define CODE_SENSOR_LINK 8'h2A
`define CODE_OVERLOAD 8'h30
`define CODE_OVERSPEED 8'h31
`define CODE_HOME_LOST 8'h33
`define CODE_PULSE_RATE 8'h34
`define CODE_STORE_BAD 8'h41
`define CODE_SENSOR_PWRUP 8'h42
`define BLINK_2 4'h2
`define BLINK_3 4'h3
`define BLINK_7 4'h7
`define BLINK_8 4'h8
`define BLINK_9 4'h9
`define FAULT_COUNT 11
`endif

// file: rtl/alarm_handler_pkg.sv
// types for the motor driver alarm handler
package alarm_handler_pkg;
    typedef enum logic [1:0] {IDLE, ALARM} mode_t;
    typedef enum logic [1:0] {CLR_ANY, CLR_NEVER, CLR_HOME} clear_t;
    typedef struct packed {
        mode_t mode;
        logic [7:0] code;
        logic [3:0] blinks;
        logic excite;
        logic brake;
        clear_t clearKind;
        logic [1:0] clrSync;
        logic [1:0] homeSync;
        logic [1:0] brakeSync;
        logic [10:0] faultSync1;
        logic [10:0] faultSync2;
        logic clrPrev;
    } state_t;
endpackage

// file: rtl/motor_driver_alarm_handler.sv
// alarm latch, code, blink count and excitation decision
`timescale 1ns/10ps
`include "alarm_handler_defines.svh"
module motor_driver_alarm_handler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [10:0] faultIn,
    input wire logic alarmClearInput,
    input wire logic homeRestored,
    input wire logic brakeFitted,
    output logic alarmActive,
    output logic [7:0] alarmCode,
    output logic [3:0] ledBlinks,
    output logic motorExcite,
    output logic brakeEngage
);
    // faultIn bit order: supply off, undervolt, motor hot, sensor run, sensor link,
    // overload, overspeed, home lost, pulse rate, store bad, sensor power-up
    alarm_handler_pkg::state_t cur, nxt;
    logic [10:0] faults;
    logic clrRise;

    // fixed priority: lowest bit wins when several detectors fire together
    function automatic logic [14:0] lookup(input logic [10:0] f);
        logic [14:0] r;
        r = {`CODE_NONE, `BLINK_2, 1'b1, 2'b00};
        if (f[0]) r = {`CODE_SUPPLY_OFF, `BLINK_3, 1'b0, 2'b00};
        else if (f[1]) r = {`CODE_UNDERVOLT, `BLINK_3, 1'b0, 2'b00};
        else if (f[2]) r = {`CODE_MOTOR_HOT, `BLINK_8, 1'b0, 2'b00};
        else if (f[3]) r = {`CODE_SENSOR_RUN, `BLINK_8, 1'b0, 2'b01};
        else if (f[4]) r = {`CODE_SENSOR_LINK, `BLINK_8, 1'b0, 2'b01};
        else if (f[5]) r = {`CODE_OVERLOAD, `BLINK_2, 1'b0, 2'b00};
        else if (f[6]) r = {`CODE_OVERSPEED, `BLINK_2, 1'b0, 2'b00};
        else if (f[7]) r = {`CODE_HOME_LOST, `BLINK_7, 1'b0, 2'b10};
        else if (f[8]) r = {`CODE_PULSE_RATE, `BLINK_2, 1'b0, 2'b00};
        else if (f[9]) r = {`CODE_STORE_BAD, `BLINK_9, 1'b0, 2'b01};
        else if (f[10]) r = {`CODE_SENSOR_PWRUP, `BLINK_8, 1'b0, 2'b01};
        return r;
    endfunction

    assign faults = cur.faultSync2;
    assign clrRise = cur.clrSync[1] & ~cur.clrPrev;

    always_comb begin
        logic [14:0] hit;
        hit = lookup(faults);
        nxt = cur;
        nxt.faultSync1 = faultIn;
        nxt.faultSync2 = cur.faultSync1;
        nxt.clrSync = {cur.clrSync[0], alarmClearInput};
        nxt.homeSync = {cur.homeSync[0], homeRestored};
        // brake option is a pin as well, so it is synchronised like the detectors
        nxt.brakeSync = {cur.brakeSync[0], brakeFitted};
        nxt.clrPrev = cur.clrSync[1];
        case (cur.mode)
            alarm_handler_pkg::IDLE: begin
                if (|faults) begin
                    nxt.mode = alarm_handler_pkg::ALARM;
                    nxt.code = hit[14:7];
                    nxt.blinks = hit[6:3];
                    nxt.excite = hit[2];
                    nxt.brake = cur.brakeSync[1] & ~hit[2];
                    nxt.clearKind = alarm_handler_pkg::clear_t'(hit[1:0]);
                end
            end
            alarm_handler_pkg::ALARM: begin
                // clear only when the cause has gone, otherwise it would re-latch at once
                if (((cur.clearKind == alarm_handler_pkg::CLR_ANY && clrRise)
                    || (cur.clearKind == alarm_handler_pkg::CLR_HOME && cur.homeSync[1]))
                    && !(|faults)) begin
                    nxt.mode = alarm_handler_pkg::IDLE;
                    nxt.code = `CODE_NONE;
                    nxt.blinks = 4'h0;
                    nxt.excite = 1'b1;
                    nxt.brake = 1'b0;
                    nxt.clearKind = alarm_handler_pkg::CLR_ANY;
                end
            end
            default: nxt.mode = alarm_handler_pkg::IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= '{mode: alarm_handler_pkg::IDLE, code: `CODE_NONE, blinks: 4'h0, excite: 1'b1, brake: 1'b0,
                clearKind: alarm_handler_pkg::CLR_ANY, clrSync: 2'h0, homeSync: 2'h0,
                brakeSync: 2'h0, faultSync1: 11'h000, faultSync2: 11'h000, clrPrev: 1'b0};
        end else begin
            cur <= nxt;
        end
    end

    always_comb begin
        alarmActive = (cur.mode == alarm_handler_pkg::ALARM);
        alarmCode = cur.code;
        ledBlinks = cur.blinks;
        motorExcite = cur.excite;
        brakeEngage = cur.brake;
    end

    property p_latch_cut;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[0]) |=> (alarmCode == 8'h23 && !motorExcite);
    endproperty
    a_latch_cut: assert property (p_latch_cut) else $error("supply loss not latched");
    property p_undervolt;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[1:0] == 2'b10) |=> (alarmCode == 8'h25 && ledBlinks == 4'h3);
    endproperty
    a_undervolt: assert property (p_undervolt) else $error("undervolt code wrong");
    property p_hot;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[2:0] == 3'b100) |=> (alarmCode == 8'h26 && ledBlinks == 4'h8);
    endproperty
    a_hot: assert property (p_hot) else $error("overheat code wrong");
    property p_no_clear;
        @(posedge clk) disable iff (!rst_n)
        (alarmActive && cur.clearKind == alarm_handler_pkg::CLR_NEVER) |=> alarmActive;
    endproperty
    a_no_clear: assert property (p_no_clear) else $error("fatal alarm cleared");
    property p_store;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[9:0] == 10'h200) |=> (alarmCode == 8'h41 && ledBlinks == 4'h9);
    endproperty
    a_store: assert property (p_store) else $error("store fault code wrong");
    property p_brake;
        @(posedge clk) disable iff (!rst_n)
        (alarmActive && !motorExcite && $past(cur.brakeSync[1]) && $rose(alarmActive)) |-> brakeEngage;
    endproperty
    a_brake: assert property (p_brake) else $error("brake not engaged");
    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (alarmActive && !clrRise && !cur.homeSync[1]) |=> $stable(alarmCode);
    endproperty
    a_hold: assert property (p_hold) else $error("code changed while latched");
    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        (alarmActive && cur.clearKind == alarm_handler_pkg::CLR_ANY && clrRise && !(|faults)) |=> !alarmActive;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");

    // one property per code; the antecedent masks lower bits so priority cannot hide the result
    property p_sensor_run;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[3:0] == 4'h8) |=> (alarmCode == 8'h28 && ledBlinks == 4'h8);
    endproperty
    a_sensor_run: assert property (p_sensor_run) else $error("sensor fault code wrong");
    property p_sensor_link;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[4:0] == 5'h10) |=> (alarmCode == 8'h2A && ledBlinks == 4'h8);
    endproperty
    a_sensor_link: assert property (p_sensor_link) else $error("sensor link code wrong");
    property p_overload;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[5:0] == 6'h20) |=> (alarmCode == 8'h30 && ledBlinks == 4'h2);
    endproperty
    a_overload: assert property (p_overload) else $error("overload code wrong");
    property p_overspeed;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[6:0] == 7'h40) |=> (alarmCode == 8'h31 && ledBlinks == 4'h2);
    endproperty
    a_overspeed: assert property (p_overspeed) else $error("overspeed code wrong");
    property p_home_lost;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[7:0] == 8'h80) |=> (alarmCode == 8'h33 && ledBlinks == 4'h7);
    endproperty
    a_home_lost: assert property (p_home_lost) else $error("home lost code wrong");
    property p_pulse_rate;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults[8:0] == 9'h100) |=> (alarmCode == 8'h34 && ledBlinks == 4'h2);
    endproperty
    a_pulse_rate: assert property (p_pulse_rate) else $error("pulse rate code wrong");
    property p_sensor_pwrup;
        @(posedge clk) disable iff (!rst_n)
        (cur.mode == alarm_handler_pkg::IDLE && faults == 11'h400) |=> (alarmCode == 8'h42 && ledBlinks == 4'h8);
    endproperty
    a_sensor_pwrup: assert property (p_sensor_pwrup) else $error("power-up sensor code wrong");
    property p_cut;
        @(posedge clk) disable iff (!rst_n)
        alarmActive |-> !motorExcite;
    endproperty
    a_cut: assert property (p_cut) else $error("current left on in alarm");
    property p_home_only;
        @(posedge clk) disable iff (!rst_n)
        (alarmActive && cur.clearKind == alarm_handler_pkg::CLR_HOME && !cur.homeSync[1]) |=> alarmActive;
    endproperty
    a_home_only: assert property (p_home_only) else $error("home alarm cleared without homing");
    property p_no_brake;
        @(posedge clk) disable iff (!rst_n)
        ($rose(alarmActive) && !$past(cur.brakeSync[1])) |-> !brakeEngage;
    endproperty
    a_no_brake: assert property (p_no_brake) else $error("brake engaged without brake fitted");
    property p_idle;
        @(posedge clk) disable iff (!rst_n)
        !alarmActive |-> (alarmCode == 8'h00 && ledBlinks == 4'h0 && motorExcite && !brakeEngage);
    endproperty
    a_idle: assert property (p_idle) else $error("idle outputs wrong");
    property p_refused;
        @(posedge clk) disable iff (!rst_n)
        (alarmActive && (|faults)) |=> alarmActive;
    endproperty
    a_refused: assert property (p_refused) else $error("alarm cleared while cause present");

    // main scenarios: raise, clear, homing, refused clear, brake
    c_alarm: cover property (@(posedge clk) disable iff (!rst_n) $rose(alarmActive));
    c_clear: cover property (@(posedge clk) disable iff (!rst_n) $fell(alarmActive));
    c_home: cover property (@(posedge clk) disable iff (!rst_n) alarmActive && alarmCode == 8'h33 ##1 !alarmActive);
    c_refused: cover property (@(posedge clk) disable iff (!rst_n) alarmActive && clrRise && (|faults) ##1 alarmActive);
    c_brake: cover property (@(posedge clk) disable iff (!rst_n) $rose(brakeEngage));
endmodule

// file: bench/host_model.sv
// host controller model driving the alarm clear input
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clearReq,
    output logic alarmClearInput
);
    logic [1:0] hold;
    // clear is held a few cycles so the synchroniser sees it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold <= 2'h0;
            alarmClearInput <= 1'b0;
        end else if (clearReq) begin
            hold <= 2'h3;
            alarmClearInput <= 1'b1;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else begin
            alarmClearInput <= 1'b0;
        end
    end
endmodule

// file: bench/testbench.sv
// self-checking bench for the alarm handler
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [10:0] faultIn = 11'h000;
    logic homeRestored = 1'b0;
    logic brakeFitted = 1'b0;
    logic clearReq = 1'b0;
    logic alarmClearInput, alarmActive, motorExcite, brakeEngage;
    logic [7:0] alarmCode;
    logic [3:0] ledBlinks;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] codes [11] = '{8'h23, 8'h25, 8'h26, 8'h28, 8'h2A, 8'h30, 8'h31, 8'h33, 8'h34, 8'h41, 8'h42};
    logic [3:0] blinks [11] = '{4'h3, 4'h3, 4'h8, 4'h8, 4'h8, 4'h2, 4'h2, 4'h7, 4'h2, 4'h9, 4'h8};
    // 0 clear input, 1 power cycle only, 2 homing only
    int kind [11] = '{0, 0, 0, 1, 1, 0, 0, 2, 0, 1, 1};
    always #50 clk = ~clk;
    // whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end
    host_model i_host_model (.clk(clk), .rst_n(rst_n), .clearReq(clearReq), .alarmClearInput(alarmClearInput));
    motor_driver_alarm_handler i_motor_driver_alarm_handler (.clk(clk), .rst_n(rst_n), .faultIn(faultIn),
        .alarmClearInput(alarmClearInput), .homeRestored(homeRestored), .brakeFitted(brakeFitted),
        .alarmActive(alarmActive), .alarmCode(alarmCode), .ledBlinks(ledBlinks), .motorExcite(motorExcite),
        .brakeEngage(brakeEngage));
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic expect_out(input logic a, input logic [7:0] c, input logic [3:0] b, input logic x, input logic k);
        check("alarmActive", {7'h00, a}, {7'h00, alarmActive});
        check("alarmCode", c, alarmCode);
        check("ledBlinks", {4'h0, b}, {4'h0, ledBlinks});
        check("motorExcite", {7'h00, x}, {7'h00, motorExcite});
        check("brakeEngage", {7'h00, k}, {7'h00, brakeEngage});
    endtask
    task automatic reset_dut(input int n);
        // at start reset is already low; mid-run it is lowered on an edge
        if (rst_n) @(posedge clk);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
        wait_cycles(2);
        expect_out(1'b0, 8'h00, 4'h0, 1'b1, 1'b0);
    endtask
    task automatic pulse_clear();
        @(posedge clk);
        clearReq <= 1'b1;
        @(posedge clk);
        clearReq <= 1'b0;
        wait_cycles(8);
    endtask
    task automatic test_fault_table();
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            brakeFitted <= i[0];
            faultIn <= 11'h001 << i;
            wait_cycles(5);
            expect_out(1'b1, codes[i], blinks[i], 1'b0, i[0]);
            @(posedge clk);
            faultIn <= 11'h000;
            wait_cycles(4);
            expect_out(1'b1, codes[i], blinks[i], 1'b0, i[0]);
            pulse_clear();
            check("cleared", {7'h00, kind[i] == 0}, {7'h00, !alarmActive});
            if (kind[i] == 2) begin
                @(posedge clk);
                homeRestored <= 1'b1;
                wait_cycles(6);
                expect_out(1'b0, 8'h00, 4'h0, 1'b1, 1'b0);
                @(posedge clk);
                homeRestored <= 1'b0;
            end else if (kind[i] == 1) begin
                reset_dut(2);
            end
        end
    endtask
    task automatic test_priority_and_refusal();
        @(posedge clk);
        brakeFitted <= 1'b1;
        faultIn <= 11'h204;
        wait_cycles(5);
        expect_out(1'b1, 8'h26, 4'h8, 1'b0, 1'b1);
        @(posedge clk);
        faultIn <= 11'h005;
        pulse_clear();
        // clear refused while a fault is still present; later fault ignored
        expect_out(1'b1, 8'h26, 4'h8, 1'b0, 1'b1);
        @(posedge clk);
        faultIn <= 11'h000;
        wait_cycles(4);
        pulse_clear();
        expect_out(1'b0, 8'h00, 4'h0, 1'b1, 1'b0);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        reset_dut(8);
        test_fault_table();
        test_priority_and_refusal();
        finish_test();
    end
endmodule
